// ==== inc/lsf_pkg.sv ====
package lsf_pkg;

  // Reference clock
  localparam int unsigned CLK_MHZ = 50;

  // Interval figures in their own units
  localparam int unsigned T_DIM_BLANK_NS = 1000;
  localparam int unsigned T_CTRL_BLANK_NS = 1000;
  localparam int unsigned T_DIM_QUAL_NS = 8000;
  localparam int unsigned T_CTRL_QUAL_NS = 4000;
  localparam int unsigned T_START_MASK_US = 1200;
  localparam int unsigned T_OPEN_REPORT_US = 12000;

  // Least times round up to whole cycles
  localparam int unsigned DIM_BLANK_TICKS = (T_DIM_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CTRL_BLANK_TICKS = (T_CTRL_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DIM_QUAL_TICKS = (T_DIM_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CTRL_QUAL_TICKS = (T_CTRL_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned START_MASK_TICKS = T_START_MASK_US * CLK_MHZ;
  localparam int unsigned OPEN_REPORT_TICKS = T_OPEN_REPORT_US * CLK_MHZ;

  // Counter widths
  localparam int unsigned SHORT_CNT_W = 9;
  localparam int unsigned LONG_CNT_W = 20;

  // Register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;

  // Control register fields
  localparam int unsigned CTL_FAULT_EN_BIT = 0;
  localparam logic CTL_FAULT_EN_RST = 1'b1;

  // Status register fields
  localparam int unsigned ST_OPEN_LSB = 0;
  localparam int unsigned ST_SHORT_LSB = 2;
  localparam int unsigned ST_RELEASE_BIT = 4;
  localparam int unsigned ST_OPEN_REP_BIT = 5;
  localparam int unsigned ST_TARGET_LSB = 8;

  // Interrupt event bits: open on string 0/1, short on string 0/1, start-up release
  localparam int unsigned IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 5'h00;
  localparam int unsigned IRQ_RELEASE_BIT = 4;

  // Regulation target selection
  typedef enum logic [2:0] {
    LSF_TGT_BOTH,
    LSF_TGT_STRING0,
    LSF_TGT_STRING1,
    LSF_TGT_OVERVOLTAGE,
    LSF_TGT_HOLD
  } lsf_target_t;

endpackage

// ==== src/lsf_interval_timer.sv ====
// Counts consecutive enabled cycles of run_i and flags when the interval is met
module lsf_interval_timer
  import lsf_pkg::*;
#(
  parameter logic [SHORT_CNT_W-1:0] TICKS = 9'h001
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  output logic done_o
);

  logic [SHORT_CNT_W-1:0] cnt_q;
  logic [SHORT_CNT_W-1:0] cnt_d;
  logic done_d;

  // Saturating count; any drop of run_i restarts the interval
  assign cnt_d = !run_i ? '0 : (cnt_q == TICKS) ? cnt_q : cnt_q + 9'h001;
  assign done_d = run_i && (cnt_d == TICKS);

  // State, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      done_o <= done_d;
    end
  end

endmodule // lsf_interval_timer

// ==== src/lsf_fault_supervisor.sv ====
// Notes on behaviour
// - Stored fault status changes only while dimming pulse is high; held while low.
// - Open fault on low headroom; short fault on low string pin per string.
// - Fault output pulled low on any reported fault while fault output enabled.
// - Start-up mask ends 1.2 ms after first rise with headroom, 8 us, 4 us.
// - Alternative start-up release when output reaches 95% of overvoltage limit.
// - On release, fault reporting starts and switching steps to full frequency.
// - A short keeps its current source off even while fault output masked.
// - Open faults reported only from 12 ms after the very first rise.
// - Comparators ignored 1 us after each dimming rise and while dimming low.
// - Evaluate only with analog level above threshold, after a 1 us blanking.
// - A detected short turns that string's current source off at once.
// - One faulted string regulates for the good one; two regulate to overvoltage.
// - Open display holds output at the overvoltage limit.
// - Analog level below threshold: both sources off, regulate to overvoltage limit.
// - Dimming low: both sources off, hold the output sampled while high.
//
// The address map and the APB slave port were decided locally.
module lsf_fault_supervisor
  import lsf_pkg::*;
#(
  parameter int unsigned START_MASK_CYCLES = START_MASK_TICKS,
  parameter int unsigned OPEN_REPORT_CYCLES = OPEN_REPORT_TICKS
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Analog side
  input wire logic enable_lockout_input_i,
  input wire logic dim_pulse_i,
  input wire logic ctrl_above_thr_i,
  input wire logic [1:0] headroom_low_i,
  input wire logic [1:0] string_pin_low_i,
  input wire logic [1:0] headroom_ok_i,
  input wire logic boost_output_voltage_near_limit_i,
  // Decisions
  output logic fault_n_o,
  output logic [1:0] src_on_o,
  output lsf_target_t reg_target_o,
  output logic freq_full_o,
  output logic irq_o,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  localparam logic [LONG_CNT_W-1:0] START_MASK_LIM = LONG_CNT_W'(START_MASK_CYCLES);
  localparam logic [LONG_CNT_W-1:0] OPEN_REPORT_LIM = LONG_CNT_W'(OPEN_REPORT_CYCLES);

  logic dim_q;
  logic ctrl_q;
  logic started_q;
  logic [LONG_CNT_W-1:0] age_q;
  logic [LONG_CNT_W-1:0] age_d;
  logic release_q;
  logic open_rep_q;
  logic [1:0] open_q;
  logic [1:0] short_q;
  logic [1:0] open_d;
  logic [1:0] short_d;
  logic fault_en_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  lsf_target_t target_d;

  // Interval timers on the reference clock
  logic dim_blank_done;
  logic ctrl_blank_done;
  logic dim_qual_done;
  logic ctrl_qual_done;
  logic run_dim;
  logic run_ctrl;

  assign run_dim = enable_lockout_input_i && dim_pulse_i;
  assign run_ctrl = enable_lockout_input_i && ctrl_above_thr_i;

  // Blanking after each dimming rise
  lsf_interval_timer #(.TICKS(SHORT_CNT_W'(DIM_BLANK_TICKS))) u_dim_blank (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(run_dim),
    .done_o(dim_blank_done)
  );

  // Blanking after the analog level rises past threshold
  lsf_interval_timer #(.TICKS(SHORT_CNT_W'(CTRL_BLANK_TICKS))) u_ctrl_blank (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(run_ctrl),
    .done_o(ctrl_blank_done)
  );

  // Start-up qualification of the dimming pulse
  lsf_interval_timer #(.TICKS(SHORT_CNT_W'(DIM_QUAL_TICKS))) u_dim_qual (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(run_dim),
    .done_o(dim_qual_done)
  );

  // Start-up qualification of the analog level
  lsf_interval_timer #(.TICKS(SHORT_CNT_W'(CTRL_QUAL_TICKS))) u_ctrl_qual (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .run_i(run_ctrl),
    .done_o(ctrl_qual_done)
  );

  // Start-up tracking: first rise only counts while enabled
  logic dim_rise;
  logic start_event;
  logic age_mask_done;
  logic age_open_done;
  logic release_cond;

  assign dim_rise = dim_pulse_i && !dim_q;
  assign start_event = enable_lockout_input_i && dim_rise && !started_q;
  assign age_open_done = started_q && (age_q >= OPEN_REPORT_LIM);
  assign age_mask_done = started_q && (age_q >= START_MASK_LIM);
  assign age_d = (!started_q || age_open_done) ? age_q : age_q + 20'h00001;

  // Either release path ends the mask
  assign release_cond = enable_lockout_input_i && started_q && (
    (age_mask_done && (&headroom_ok_i) && dim_qual_done && ctrl_qual_done) ||
    boost_output_voltage_near_limit_i);

  // Fault evaluation window: dimming high and analog level up, both past blanking
  logic eval;

  assign eval = run_dim && dim_blank_done && run_ctrl && ctrl_blank_done;

  // Comparator sampling, held outside the window
  assign open_d = eval ? headroom_low_i : open_q;
  assign short_d = eval ? string_pin_low_i : short_q;

  // Open faults count only once their reporting delay has passed
  logic [1:0] open_rep_d;
  logic [1:0] bad_d;
  logic any_report_d;

  assign open_rep_d = (age_open_done || open_rep_q) ? open_d : 2'h0;
  assign bad_d = open_rep_d | short_d;
  assign any_report_d = |bad_d;

  // Regulation target selection
  always_comb begin
    target_d = LSF_TGT_BOTH;
    if (!enable_lockout_input_i || !ctrl_above_thr_i) begin
      target_d = LSF_TGT_OVERVOLTAGE;
    end else if (!dim_pulse_i) begin
      target_d = LSF_TGT_HOLD;
    end else if (&bad_d) begin
      target_d = LSF_TGT_OVERVOLTAGE;
    end else if (bad_d[0]) begin
      target_d = LSF_TGT_STRING1;
    end else if (bad_d[1]) begin
      target_d = LSF_TGT_STRING0;
    end
  end

  // Input edge history and start-up state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dim_q <= 1'b0;
      ctrl_q <= 1'b0;
      started_q <= 1'b0;
      age_q <= '0;
    end else if (ce_i) begin
      dim_q <= dim_pulse_i;
      ctrl_q <= ctrl_above_thr_i;
      started_q <= enable_lockout_input_i && (started_q || start_event);
      age_q <= enable_lockout_input_i ? age_d : '0;
    end
  end

  // Release and open-report gates; dropping enable restarts the sequence
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      release_q <= 1'b0;
      open_rep_q <= 1'b0;
    end else if (ce_i) begin
      release_q <= enable_lockout_input_i && (release_q || release_cond);
      open_rep_q <= enable_lockout_input_i && (open_rep_q || age_open_done);
    end
  end

  // Latched fault status; a short is acted on even while the flag is masked
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      open_q <= 2'h0;
      short_q <= 2'h0;
    end else if (ce_i) begin
      open_q <= enable_lockout_input_i ? open_d : 2'h0;
      short_q <= enable_lockout_input_i ? short_d : 2'h0;
    end
  end

  // Pin-facing decisions, all registered
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fault_n_o <= 1'b1;
      src_on_o <= 2'h0;
      reg_target_o <= LSF_TGT_OVERVOLTAGE;
      freq_full_o <= 1'b0;
    end else if (ce_i) begin
      fault_n_o <= !(release_q && fault_en_q && any_report_d);
      src_on_o <= {2{run_dim && run_ctrl}} & ~short_d;
      reg_target_o <= target_d;
      freq_full_o <= release_q || release_cond;
    end
  end

  // Interrupt events: new open or short per string and start-up release
  // An open latched before its report time still raises its event once reporting starts
  assign irq_set = {release_cond && !release_q, short_d & ~short_q,
    open_rep_d & ~(open_q & {2{open_rep_q}})};

  // APB slave with one wait state so every answer leaves a flop
  logic apb_access;
  logic apb_done;
  logic hit_ctl;
  logic hit_st;
  logic hit_ist;
  logic hit_icl;
  logic hit_ien;
  logic addr_ok;
  logic [31:0] rdata_d;
  logic [31:0] status_word;

  assign apb_access = psel_i && penable_i && !pready_o;
  assign apb_done = psel_i && penable_i && pready_o;
  assign hit_ctl = paddr_i == ADDR_CONTROL;
  assign hit_st = paddr_i == ADDR_STATUS;
  assign hit_ist = paddr_i == ADDR_IRQ_STATUS;
  assign hit_icl = paddr_i == ADDR_IRQ_CLEAR;
  assign hit_ien = paddr_i == ADDR_IRQ_ENABLE;
  assign addr_ok = hit_ctl || hit_st || hit_ist || hit_icl || hit_ien;
  assign irq_clr = (apb_done && pwrite_i && hit_icl) ? pwdata_i[IRQ_W-1:0] : '0;

  assign status_word = {21'h000000, reg_target_o, 2'h0, open_rep_q, release_q,
    short_q, open_q};

  // Read mux; the clear register reads as zero
  assign rdata_d = hit_ctl ? {31'h00000000, fault_en_q} :
                   hit_st ? status_word :
                   hit_ist ? {27'h0000000, irq_stat_q} :
                   hit_ien ? {27'h0000000, irq_en_q} : 32'h00000000;

  // Bus handshake and read data capture
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (ce_i) begin
      pready_o <= apb_access;
      pslverr_o <= apb_access && !addr_ok;
      prdata_o <= (apb_access && !pwrite_i) ? rdata_d : 32'h00000000;
    end
  end

  // Writable registers; a write lands at the edge that completes the transfer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fault_en_q <= CTL_FAULT_EN_RST;
      irq_en_q <= IRQ_EN_RST;
    end else if (ce_i && apb_done && pwrite_i) begin
      if (hit_ctl) begin
        fault_en_q <= pwdata_i[CTL_FAULT_EN_BIT];
      end
      if (hit_ien) begin
        irq_en_q <= pwdata_i[IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins so nothing is lost
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_stat_q <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_o <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

endmodule // lsf_fault_supervisor

// ==== tb/lsf_dim_source.sv ====
// Far-side dimming controller: raises enable, then runs fixed dimming pulses
module lsf_dim_source (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic hold_i,
  output logic en_o,
  output logic dim_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  // Period of 200 cycles, high 150: well above the 1 us floor for detection
  // Hold keeps the pulse high, long enough for start-up qualification
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !run_i) begin
      en_o <= 1'h0;
      dim_o <= 1'h0;
      cnt_q <= 8'h00;
    end else begin
      en_o <= 1'h1;
      cnt_q <= (cnt_q == 8'hc7) ? 8'h00 : cnt_q + 8'h01;
      dim_o <= en_o && (hold_i || cnt_q >= 8'h32);
    end
  end
endmodule // lsf_dim_source

// ==== tb/lsf_fault_supervisor_properties.sv ====
module lsf_fault_supervisor_properties
  import lsf_pkg::*;
#(
  parameter int unsigned START_MASK_CYCLES = START_MASK_TICKS,
  parameter int unsigned OPEN_REPORT_CYCLES = OPEN_REPORT_TICKS
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic enable_lockout_input_i,
  input wire logic dim_pulse_i,
  input wire logic ctrl_above_thr_i,
  input wire logic [1:0] string_pin_low_i,
  input wire logic boost_output_voltage_near_limit_i,
  input wire logic fault_n_o,
  input wire logic [1:0] src_on_o,
  input wire lsf_target_t reg_target_o,
  input wire logic freq_full_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] dim_q, ctl_q;
  logic eval_ok;
  // Saturating runs of high cycles; judged late by one so a slow design is not flagged
  always_ff @(posedge clk_i) begin
    dim_q <= (sys_rst_i || !dim_pulse_i || !enable_lockout_input_i) ? 7'h00 :
             dim_q + {6'h00, dim_q != 7'h7f};
    ctl_q <= (sys_rst_i || !ctrl_above_thr_i) ? 7'h00 : ctl_q + {6'h00, ctl_q != 7'h7f};
  end
  assign eval_ok = dim_q > 7'(DIM_BLANK_TICKS) && ctl_q > 7'(CTRL_BLANK_TICKS);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i || !ce_i);
  dim_low_off_a: assert property (!dim_pulse_i |=> src_on_o == 2'h0)
    else $error("sources on while dimming low");
  dim_low_hold_a: assert property (
    enable_lockout_input_i && ctrl_above_thr_i && !dim_pulse_i |=> reg_target_o == LSF_TGT_HOLD)
    else $error("no hold target while dimming low");
  ctrl_low_off_a: assert property (
    !ctrl_above_thr_i |=> src_on_o == 2'h0 && reg_target_o == LSF_TGT_OVERVOLTAGE)
    else $error("analog level low not honoured");
  start_mask_a: assert property (!freq_full_o && !$past(freq_full_o) |-> fault_n_o)
    else $error("fault flag before release");
  limit_release_a: assert property (
    enable_lockout_input_i && boost_output_voltage_near_limit_i |-> ##[1:2] freq_full_o)
    else $error("no release at output limit");
  release_keep_a: assert property (freq_full_o && enable_lockout_input_i |=> freq_full_o)
    else $error("release dropped");
  short_off_a: assert property (
    eval_ok && string_pin_low_i[0] |-> ##[1:2] !src_on_o[0])
    else $error("source on with short");
  fault_low_a: assert property (
    eval_ok && freq_full_o && string_pin_low_i != 2'h0 |-> ##[1:3] !fault_n_o)
    else $error("short not flagged");
  blank_hold_a: assert property ($rose(dim_pulse_i) && fault_n_o |=> fault_n_o [*8])
    else $error("flag moved in blanking");
  enable_clear_a: assert property (
    !enable_lockout_input_i [*2] |=> fault_n_o && !freq_full_o && src_on_o == 2'h0)
    else $error("enable low did not clear");
endmodule // lsf_fault_supervisor_properties

bind lsf_fault_supervisor lsf_fault_supervisor_properties #(
  .START_MASK_CYCLES(START_MASK_CYCLES), .OPEN_REPORT_CYCLES(OPEN_REPORT_CYCLES)
) lsf_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .enable_lockout_input_i(enable_lockout_input_i), .dim_pulse_i(dim_pulse_i),
  .ctrl_above_thr_i(ctrl_above_thr_i), .string_pin_low_i(string_pin_low_i),
  .boost_output_voltage_near_limit_i(boost_output_voltage_near_limit_i),
  .fault_n_o(fault_n_o), .src_on_o(src_on_o), .reg_target_o(reg_target_o),
  .freq_full_o(freq_full_o));

// ==== tb/testbench.sv ====
module testbench import lsf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0, sys_rst_i = 1'h1, run = 1'h0, ctrl = 1'h1, near = 1'h0;
  logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0, en, dim, e, hold = 1'h0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic [1:0] hr_low = 2'h0, pin_low = 2'h0, hr_ok = 2'h0, src_on_o;
  logic fault_n_o, freq_full_o, irq_o, pready_o, pslverr_o;
  lsf_target_t reg_target_o;
  int n_errors = 0, checked = 0;
  always #10 clk_i = ~clk_i;
  // Short counts keep the start-up and open-report spans inside a brief run
  lsf_fault_supervisor #(.START_MASK_CYCLES(20), .OPEN_REPORT_CYCLES(80))
  lsf_fault_supervisor_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'h1), .enable_lockout_input_i(en),
    .dim_pulse_i(dim), .ctrl_above_thr_i(ctrl), .headroom_low_i(hr_low),
    .string_pin_low_i(pin_low), .headroom_ok_i(hr_ok),
    .boost_output_voltage_near_limit_i(near), .fault_n_o(fault_n_o), .src_on_o(src_on_o),
    .reg_target_o(reg_target_o), .freq_full_o(freq_full_o), .irq_o(irq_o),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
  lsf_dim_source lsf_dim_source_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .run_i(run), .hold_i(hold), .en_o(en), .dim_o(dim));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // One APB transfer; pready and read data are taken at the edge that completes it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    r = prdata_o;
    e = pslverr_o;
    chk(pready_o, 1'h1);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(r & m, x);
  endtask
  task automatic t_regs();
    rdc(ADDR_CONTROL, 32'hffffffff, 32'h1);
    rdc(ADDR_IRQ_ENABLE, 32'h1f, 32'h0);
    rdc(ADDR_IRQ_STATUS, 32'h1f, 32'h0);
    apb(1'h1, ADDR_IRQ_ENABLE, 32'h1f);
    rdc(ADDR_IRQ_ENABLE, 32'h1f, 32'h1f);
    rdc(ADDR_IRQ_CLEAR, 32'hffffffff, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    chk(e, 1'h1);
    apb(1'h1, ADDR_IRQ_ENABLE, 32'h10);
  endtask
  task automatic t_mask();
    run <= 1'h1;
    @(posedge dim);
    cyc(60);
    pin_low <= 2'h1;
    cyc(5);
    chk(src_on_o, 2'h2);
    chk(fault_n_o, 1'h1);
    chk(reg_target_o, LSF_TGT_STRING1);
    rdc(ADDR_STATUS, 32'h71f, 32'h204);
    @(negedge dim);
    pin_low <= 2'h0;
    cyc(3);
    chk(reg_target_o, LSF_TGT_HOLD);
    rdc(ADDR_STATUS, 32'hc, 32'h4);
  endtask
  task automatic t_release();
    near <= 1'h1;
    cyc(3);
    chk(freq_full_o, 1'h1);
    chk(irq_o, 1'h1);
    chk(fault_n_o, 1'h0);
    near <= 1'h0;
    apb(1'h1, ADDR_IRQ_CLEAR, 32'h1f);
    chk(irq_o, 1'h0);
    apb(1'h1, ADDR_CONTROL, 32'h0);
    cyc(2);
    chk(fault_n_o, 1'h1);
    apb(1'h1, ADDR_CONTROL, 32'h1);
  endtask
  task automatic t_both();
    @(posedge dim);
    cyc(60);
    pin_low <= 2'h3;
    cyc(5);
    chk(src_on_o, 2'h0);
    chk(reg_target_o, LSF_TGT_OVERVOLTAGE);
    chk(fault_n_o, 1'h0);
    pin_low <= 2'h0;
  endtask
  // Fresh start: short inside blanking, then an open before and after its report time
  task automatic t_open();
    run <= 1'h0;
    cyc(3);
    rdc(ADDR_STATUS, 32'h1f, 32'h0);
    run <= 1'h1;
    @(posedge dim);
    // Output can only approach its limit once the converter has started
    near <= 1'h1;
    pin_low <= 2'h1;
    cyc(30);
    pin_low <= 2'h0;
    cyc(25);
    hr_low <= 2'h2;
    cyc(3);
    chk(fault_n_o, 1'h1);
    cyc(30);
    chk(fault_n_o, 1'h0);
    chk(reg_target_o, LSF_TGT_STRING0);
    rdc(ADDR_STATUS, 32'h3f, 32'h32);
    rdc(ADDR_IRQ_STATUS, 32'h3, 32'h2);
    hr_low <= 2'h0;
    @(posedge dim);
    cyc(60);
    ctrl <= 1'h0;
    cyc(3);
    chk(src_on_o, 2'h0);
    chk(reg_target_o, LSF_TGT_OVERVOLTAGE);
    ctrl <= 1'h1;
    pin_low <= 2'h2;
    cyc(30);
    pin_low <= 2'h0;
    rdc(ADDR_STATUS, 32'hc, 32'h0);
  endtask
  // Fresh start with a long pulse: release needs qualification and headroom on both strings
  task automatic t_start();
    near <= 1'h0;
    run <= 1'h0;
    hold <= 1'h1;
    hr_ok <= 2'h3;
    cyc(3);
    run <= 1'h1;
    @(posedge dim);
    cyc(DIM_QUAL_TICKS - 10);
    chk(freq_full_o, 1'h0);
    hr_ok <= 2'h1;
    cyc(20);
    chk(freq_full_o, 1'h0);
    hr_ok <= 2'h3;
    cyc(3);
    chk(freq_full_o, 1'h1);
    chk(fault_n_o, 1'h1);
    hold <= 1'h0;
  endtask
  task automatic final_report();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole sequence needs about 1200 cycles; over fifteen times that means a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    cyc(1);
    t_regs();
    t_mask();
    t_release();
    t_both();
    t_open();
    t_start();
    final_report();
  end
endmodule // testbench
